// ===== design/isc_params_params.svh
// constants of the image statistics and configuration register slice
// assumes inclusion by bare name from the package, ahead of the design files
`ifndef ISC_PARAMS_PARAMS_SVH
`define ISC_PARAMS_PARAMS_SVH
// register offsets, 7-bit address field of the serial command byte
`define ISC_OFS_SUM        7'h06
`define ISC_OFS_PEAK       7'h07
`define ISC_OFS_SPARE_08   7'h08
`define ISC_OFS_SPARE_09   7'h09
`define ISC_OFS_SETUP      7'h0a
`define ISC_OFS_SETUP_EXT  7'h0b
`define ISC_OFS_RESULT_LO  7'h0c
`define ISC_OFS_RESULT_HI  7'h0d
// field positions
`define ISC_SETUP_GATE_BIT 6
`define ISC_SETUP_TEST_BIT 5
`define ISC_SETUP_DENS_BIT 4
`define ISC_EXT_BUSY_BIT   7
`define ISC_EXT_PULL_BIT   2
`define ISC_EXT_GAIN_BIT   1
`define ISC_EXT_LOCK_BIT   0
// reset values
`define ISC_SUM_RST        8'h00
`define ISC_PEAK_RST       8'h00
`define ISC_SETUP_RST      8'h09
`define ISC_EXT_RST        8'h00
`define ISC_RESULT_RST     16'h0000
`define ISC_TEST_SIGNATURE 16'h1bbf
// self-check duration
`define ISC_TEST_TIME_MS   200
`define ISC_SYS_CLK_KHZ    100000
`define ISC_TEST_CYCLES    (`ISC_TEST_TIME_MS * `ISC_SYS_CLK_KHZ)
`endif

// ===== design/isc_pkg.sv
// types shared by the register slice and its serial front end
// assumes the constants header sits beside it
`include "isc_params_params.svh"
package isc_pkg;
  typedef enum logic [1:0] {
    TEST_IDLE,
    TEST_RUN,
    TEST_DONE
  } isc_test_state_t;
  typedef logic [6:0] isc_addr_t;
  typedef logic [7:0] isc_byte_t;
endpackage : isc_pkg

// ===== design/isc_frame_stats.sv
// per-frame pixel sum and peak level, on the system clock
// assumes one pixel per valid cycle and a last flag on the final pixel
`timescale 1ns/1ns
`default_nettype none
module isc_frame_stats (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // pixel stream
  input  wire logic       pix_valid,
  input  wire logic [5:0] pix_value,
  input  wire logic       pix_last,
  // committed frame results
  output logic      [7:0] sum_bits,
  output logic      [5:0] peak_bits,
  output logic            frame_done
);
  logic [15:0] acc;
  logic [5:0]  run_max;
  logic [15:0] next_acc;
  logic [5:0]  next_max;

  assign next_acc = acc + {10'h000, pix_value};
  assign next_max = (pix_value > run_max) ? pix_value : run_max;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc        <= 16'h0000;
      run_max    <= 6'h00;
      sum_bits   <= `ISC_SUM_RST;
      peak_bits  <= 6'h00;
      frame_done <= 1'b0;
    end else if (ce) begin
      frame_done <= pix_valid & pix_last;
      if (pix_valid && pix_last) begin
        sum_bits  <= next_acc[15:8];
        peak_bits <= next_max;
        acc       <= 16'h0000;
        run_max   <= 6'h00;
      end else if (pix_valid) begin
        acc     <= next_acc;
        run_max <= next_max;
      end
    end
  end
endmodule : isc_frame_stats
`default_nettype wire

// ===== design/isc_serial_port.sv
// four-wire serial front end, clocked by the host's serial clock
// assumes clock idles high, host drives on falling and samples on rising
`timescale 1ns/1ns
`default_nettype none
module isc_serial_port
  import isc_pkg::*;
(
  // reset and link pins
  input  wire logic            rst_n,
  input  wire logic            sclk,
  input  wire logic            ncs,
  input  wire logic            mosi,
  output logic                 miso,
  output logic                 miso_oe,
  // read request and answer word
  output logic                 rd_tgl,
  output isc_pkg::isc_addr_t   rd_addr,
  input  wire isc_pkg::isc_byte_t rd_word,
  // write event
  output logic                 wr_tgl,
  output isc_pkg::isc_addr_t   wr_addr,
  output isc_pkg::isc_byte_t   wr_data
);
  logic [4:0] bit_cnt;
  logic [6:0] in_sh;
  logic       is_write;
  logic [7:0] out_sh;
  logic [7:0] next_byte;

  assign next_byte = {in_sh, mosi};

  // chip select high restarts the frame without waiting for a clock edge
  always_ff @(posedge sclk or posedge ncs) begin
    if (ncs) begin
      bit_cnt  <= 5'h00;
      in_sh    <= 7'h00;
      is_write <= 1'b0;
    end else begin
      in_sh <= next_byte[6:0];
      if (bit_cnt != 5'h10) bit_cnt <= bit_cnt + 5'h01;
      if (bit_cnt == 5'h07) is_write <= next_byte[7];
    end
  end

  // toggles survive chip select so that no event is ever lost
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_tgl  <= 1'b0;
      rd_addr <= 7'h00;
      wr_tgl  <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (!ncs) begin
      if (bit_cnt == 5'h07) begin
        rd_addr <= next_byte[6:0];
        wr_addr <= next_byte[6:0];
        if (!next_byte[7]) rd_tgl <= ~rd_tgl;
      end
      if (bit_cnt == 5'h0f && is_write) begin
        wr_data <= next_byte;
        wr_tgl  <= ~wr_tgl;
      end
    end
  end

  // rd_word is quasi-static here: the host waits before the data byte
  always_ff @(negedge sclk or posedge ncs) begin
    if (ncs) begin
      out_sh <= 8'h00;
    end else if (bit_cnt == 5'h08 && !is_write) begin
      out_sh <= rd_word;
    end else begin
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  assign miso    = out_sh[7];
  assign miso_oe = ~ncs;
endmodule : isc_serial_port
`default_nettype wire

// ===== design/isc_regs.sv
// image statistics and configuration register slice of a motion sensor
// top level: serial front end on the host clock, registers on SYS_CLK
// assumes pixel stream, illumination and busy come from SYS_CLK logic
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - sum register reports top byte of 900-pixel sum
// - sum value 0 to 221, updates each frame
// - peak register holds frame maximum, bits 7-6 zero
// - setup register read/write, resets to 0x09
// - gating bit low keeps LED on always
// - self-check bit starts tests, result into result pair
// - self-check end restores default configuration
// - self-check lasts 200 ms
// - resolution bit selects 400 or 1600 counts
// - extended setup: busy, pull-up, gain, rate lock
// - busy flags unsafe bound writes to host
// - pull-up disable bit switches pull-ups off
// - gain-off bit stops gain loop, fixed exposure
// - rate-lock bit fixes frame period
module isc_regs
  import isc_pkg::*;
#(
  parameter int TEST_CYCLES = `ISC_TEST_CYCLES
) (
  // system clock, reset and clock enable
  input  wire logic       SYS_CLK,
  input  wire logic       NRST,
  input  wire logic       CLK_EN,
  // serial port pins
  input  wire logic       SCLK,
  input  wire logic       NCS,
  input  wire logic       MOSI,
  output logic            MISO,
  output logic            MISO_OE,
  // pixel stream from the imager
  input  wire logic       PIX_VALID,
  input  wire logic [5:0] PIX_VALUE,
  input  wire logic       PIX_LAST,
  // frame timing status
  input  wire logic       ILLUM_NEEDED,
  input  wire logic       BOUND_BUSY,
  // configuration outputs
  output logic            LED_CTRL,
  output logic            COUNT_DENSITY_SELECT,
  output logic            PORT_PULLUP_ON,
  output logic            GAIN_LOOP_OFF,
  output logic            FRAME_RATE_LOCK,
  // self-check and frame status
  output logic            SELF_TEST_RUN,
  output logic [15:0]     TEST_RESULT,
  output logic            FRAME_DONE
);
  import isc_pkg::*;

  localparam logic [24:0] TEST_LAST = 25'(TEST_CYCLES - 1);
  localparam isc_byte_t   SETUP_RST = `ISC_SETUP_RST;

  // link side
  logic        rd_tgl;
  isc_addr_t   rd_addr;
  logic        wr_tgl;
  isc_addr_t   wr_addr;
  isc_byte_t   wr_data;
  isc_byte_t   rd_word;

  // crossing stages
  logic [2:0]  rd_sync;
  logic [2:0]  wr_sync;
  logic        rd_event;
  logic        wr_event;

  // frame statistics
  logic [7:0]  sum_bits;
  logic [5:0]  peak_bits;
  logic        frame_done;

  // configuration state
  logic        illum_gating;
  logic        count_density_select;
  logic        port_pullup_off;
  logic        gain_loop_off;
  logic        frame_rate_lock;

  // self-check state
  isc_test_state_t test_state;
  logic [24:0] test_cnt;
  logic [15:0] test_result;
  logic        test_start;

  // read path
  isc_byte_t   setup_view;
  isc_byte_t   ext_view;
  isc_byte_t   next_rd_word;

  isc_serial_port u_port (
    .rst_n   (NRST),
    .sclk    (SCLK),
    .ncs     (NCS),
    .mosi    (MOSI),
    .miso    (MISO),
    .miso_oe (MISO_OE),
    .rd_tgl  (rd_tgl),
    .rd_addr (rd_addr),
    .rd_word (rd_word),
    .wr_tgl  (wr_tgl),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );

  isc_frame_stats u_stats (
    .clk        (SYS_CLK),
    .rst_n      (NRST),
    .ce         (CLK_EN),
    .pix_valid  (PIX_VALID),
    .pix_value  (PIX_VALUE),
    .pix_last   (PIX_LAST),
    .sum_bits   (sum_bits),
    .peak_bits  (peak_bits),
    .frame_done (frame_done)
  );

  // toggle synchronisers; only stages 1 and 2 feed the edge detector
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_sync <= 3'h0;
      wr_sync <= 3'h0;
    end else if (CLK_EN) begin
      rd_sync <= {rd_sync[1:0], rd_tgl};
      wr_sync <= {wr_sync[1:0], wr_tgl};
    end
  end

  assign rd_event = rd_sync[2] ^ rd_sync[1];
  assign wr_event = wr_sync[2] ^ wr_sync[1];

  // a write arriving while the self-check runs is dropped on purpose
  assign test_start = wr_event && (wr_addr == `ISC_OFS_SETUP)
                      && wr_data[`ISC_SETUP_TEST_BIT]
                      && (test_state == TEST_IDLE);

  // primary setup fields
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      illum_gating         <= SETUP_RST[`ISC_SETUP_GATE_BIT];
      count_density_select <= SETUP_RST[`ISC_SETUP_DENS_BIT];
    end else if (CLK_EN) begin
      if (test_state == TEST_DONE) begin
        // self-check leaves the defaults behind
        illum_gating         <= SETUP_RST[`ISC_SETUP_GATE_BIT];
        count_density_select <= SETUP_RST[`ISC_SETUP_DENS_BIT];
      end else if (wr_event && test_state == TEST_IDLE &&
                   wr_addr == `ISC_OFS_SETUP) begin
        illum_gating         <= wr_data[`ISC_SETUP_GATE_BIT];
        count_density_select <= wr_data[`ISC_SETUP_DENS_BIT];
      end
    end
  end

  // extended setup fields; busy is a live view, never stored
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      port_pullup_off <= 1'b0;
      gain_loop_off   <= 1'b0;
      frame_rate_lock <= 1'b0;
    end else if (CLK_EN) begin
      if (test_state == TEST_DONE) begin
        port_pullup_off <= 1'b0;
        gain_loop_off   <= 1'b0;
        frame_rate_lock <= 1'b0;
      end else if (wr_event && test_state == TEST_IDLE &&
                   wr_addr == `ISC_OFS_SETUP_EXT) begin
        port_pullup_off <= wr_data[`ISC_EXT_PULL_BIT];
        gain_loop_off   <= wr_data[`ISC_EXT_GAIN_BIT];
        frame_rate_lock <= wr_data[`ISC_EXT_LOCK_BIT];
      end
    end
  end

  // self-check sequencer
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      test_state <= TEST_IDLE;
      test_cnt   <= 25'h0000000;
    end else if (CLK_EN) begin
      case (test_state)
        TEST_IDLE: begin
          if (test_start) begin
            test_state <= TEST_RUN;
            test_cnt   <= TEST_LAST;
          end
        end
        TEST_RUN: begin
          if (test_cnt == 25'h0000000) begin
            test_state <= TEST_DONE;
          end else begin
            test_cnt <= test_cnt - 25'h0000001;
          end
        end
        TEST_DONE: begin
          test_state <= TEST_IDLE;
        end
        default: begin
          test_state <= TEST_IDLE;
        end
      endcase
    end
  end

  // result word is posted when the check ends; stale value reads meanwhile
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      test_result <= `ISC_RESULT_RST;
    end else if (CLK_EN) begin
      if (test_state == TEST_DONE) begin
        test_result <= `ISC_TEST_SIGNATURE;
      end
    end
  end

  // register views; reserved setup bits keep their reset value
  always_comb begin
    setup_view = `ISC_SETUP_RST;
    setup_view[7] = 1'b0;
    setup_view[`ISC_SETUP_GATE_BIT] = illum_gating;
    setup_view[`ISC_SETUP_TEST_BIT] = (test_state != TEST_IDLE);
    setup_view[`ISC_SETUP_DENS_BIT] = count_density_select;
  end

  always_comb begin
    ext_view = `ISC_EXT_RST;
    ext_view[`ISC_EXT_BUSY_BIT] = BOUND_BUSY;
    ext_view[`ISC_EXT_PULL_BIT] = port_pullup_off;
    ext_view[`ISC_EXT_GAIN_BIT] = gain_loop_off;
    ext_view[`ISC_EXT_LOCK_BIT] = frame_rate_lock;
  end

  // read decode; unmapped and spare addresses answer zero
  always_comb begin
    if (rd_addr == `ISC_OFS_SUM) begin
      next_rd_word = sum_bits;
    end else if (rd_addr == `ISC_OFS_PEAK) begin
      next_rd_word = {2'b00, peak_bits};
    end else if (rd_addr == `ISC_OFS_SETUP) begin
      next_rd_word = setup_view;
    end else if (rd_addr == `ISC_OFS_SETUP_EXT) begin
      next_rd_word = ext_view;
    end else if (rd_addr == `ISC_OFS_RESULT_LO) begin
      next_rd_word = test_result[7:0];
    end else if (rd_addr == `ISC_OFS_RESULT_HI) begin
      next_rd_word = test_result[15:8];
    end else begin
      next_rd_word = 8'h00;
    end
  end

  // captured once per read request so the link sees a steady byte
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_word <= 8'h00;
    end else if (CLK_EN) begin
      if (rd_event) rd_word <= next_rd_word;
    end
  end

  // LED drive is registered to keep glitches off the pin
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      LED_CTRL <= 1'b1;
    end else if (CLK_EN) begin
      LED_CTRL <= illum_gating ? ILLUM_NEEDED : 1'b1;
    end
  end

  assign COUNT_DENSITY_SELECT = count_density_select;
  assign PORT_PULLUP_ON       = ~port_pullup_off;
  assign GAIN_LOOP_OFF        = gain_loop_off;
  assign FRAME_RATE_LOCK      = frame_rate_lock;
  assign SELF_TEST_RUN        = (test_state == TEST_RUN);
  assign TEST_RESULT          = test_result;
  assign FRAME_DONE           = frame_done;
endmodule : isc_regs
`default_nettype wire

// ===== dv/isc_host_model.sv
// host-side serial master: mode 3 frames, msb first, 30 ns bit time
// assumes the slice samples MOSI on SCLK rise and shifts MISO on fall
`timescale 1ns/1ns
`default_nettype none
module isc_host_model (
  // link pins
  output logic      SCLK,
  output logic      NCS,
  output logic      MOSI,
  input  wire logic MISO
);
  initial begin
    SCLK = 1'b1;
    NCS  = 1'b1;
    MOSI = 1'b0;
  end
  // the clock only moves inside a frame
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SCLK = 1'b0;
      MOSI = tx[i];
      #15;
      SCLK = 1'b1;
      rx[i] = MISO;
      #15;
    end
  endtask : shift
  // callers keep setup bit 7 zero, leave bound registers alone and stay
  // off the port while the self-check runs
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] din,
                      output logic [7:0] dout);
    logic [7:0] junk;
    #7;
    NCS = 1'b0;
    shift(cmd, junk);
    // gap lets the read word cross into the link domain
    #100;
    shift(din, dout);
    NCS  = 1'b1;
    // released line must not look like held data
    MOSI = ~MOSI;
    #100;
  endtask : xfer
endmodule : isc_host_model
`default_nettype wire

// ===== dv/isc_regs_monitor.sv
// checker for the register slice, bound onto its top module
// assumes TEST_CYCLES matches the instance it watches
`timescale 1ns/1ns
`default_nettype none
module isc_regs_monitor #(
  parameter int TEST_CYCLES = 50
) (
  // clocking
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        CLK_EN,
  // stream and status
  input wire logic        PIX_VALID,
  input wire logic        PIX_LAST,
  input wire logic        ILLUM_NEEDED,
  // outputs watched
  input wire logic        LED_CTRL,
  input wire logic        COUNT_DENSITY_SELECT,
  input wire logic        PORT_PULLUP_ON,
  input wire logic        GAIN_LOOP_OFF,
  input wire logic        FRAME_RATE_LOCK,
  input wire logic        SELF_TEST_RUN,
  input wire logic [15:0] TEST_RESULT,
  input wire logic        FRAME_DONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  logic last_take;
  int   run_cnt;
  assign last_take = PIX_VALID & PIX_LAST & CLK_EN;
  // length of the current check, in enabled cycles
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) run_cnt <= 0;
    else if (!SELF_TEST_RUN) run_cnt <= 0;
    else if (CLK_EN) run_cnt <= run_cnt + 1;
  end
  property p_led_low;
    !LED_CTRL && $past(CLK_EN) |-> !$past(ILLUM_NEEDED);
  endproperty
  a_led_low: assert property (p_led_low)
    else $error("led off while light was needed");
  property p_led_rise;
    ILLUM_NEEDED && CLK_EN |=> LED_CTRL;
  endproperty
  a_led_rise: assert property (p_led_rise)
    else $error("led not lit on demand");
  property p_frame;
    FRAME_DONE |-> $past(last_take);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame done without a last pixel");
  property p_run_len;
    $fell(SELF_TEST_RUN) |->
      run_cnt >= TEST_CYCLES && run_cnt <= TEST_CYCLES + 1;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("self-check length wrong");
  property p_result;
    $fell(SELF_TEST_RUN) |-> ##[0:2] TEST_RESULT == 16'h1bbf;
  endproperty
  a_result: assert property (p_result)
    else $error("self-check result word wrong");
  property p_restore;
    $fell(SELF_TEST_RUN) |-> ##[0:2] (!COUNT_DENSITY_SELECT &&
      PORT_PULLUP_ON && !GAIN_LOOP_OFF && !FRAME_RATE_LOCK);
  endproperty
  a_restore: assert property (p_restore)
    else $error("configuration not restored after check");
  property p_result_hold;
    $changed(TEST_RESULT) |-> $past(SELF_TEST_RUN) ||
      $past(SELF_TEST_RUN, 2);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result word moved outside a check");
  property p_frozen;
    SELF_TEST_RUN && $past(SELF_TEST_RUN) |->
      $stable(GAIN_LOOP_OFF) && $stable(COUNT_DENSITY_SELECT);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("configuration moved during check");
  c_run: cover property ($rose(SELF_TEST_RUN));
  c_frame: cover property (FRAME_DONE);
  c_led_off: cover property (!LED_CTRL);
endmodule : isc_regs_monitor
bind isc_regs isc_regs_monitor #(.TEST_CYCLES(TEST_CYCLES)) mon_u (
  .SYS_CLK, .NRST, .CLK_EN, .PIX_VALID, .PIX_LAST, .ILLUM_NEEDED,
  .LED_CTRL, .COUNT_DENSITY_SELECT, .PORT_PULLUP_ON, .GAIN_LOOP_OFF,
  .FRAME_RATE_LOCK, .SELF_TEST_RUN, .TEST_RESULT, .FRAME_DONE);
`default_nettype wire

// ===== dv/image_stats_and_config_regs_test.sv
// self-checking bench for the register slice with a host model
// assumes the check length is shortened through TEST_CYCLES
`timescale 1ns/1ns
`default_nettype none
module image_stats_and_config_regs_test;
  import isc_pkg::*;
  localparam int TC = 50;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        sclk, ncs, mosi, miso, miso_oe;
  logic        pix_valid = 1'b0;
  logic [5:0]  pix_value = 6'h00;
  logic        pix_last = 1'b0;
  logic        illum = 1'b0;
  logic        busy = 1'b0;
  logic        led, dens, pull_on, gain_off, rate_lock, run, done;
  logic [15:0] result;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          check_count = 0;
  always #5 sys_clk = ~sys_clk;
  isc_regs #(.TEST_CYCLES(TC)) dut_u (
    .SYS_CLK(sys_clk), .NRST(nrst), .CLK_EN(clk_en), .SCLK(sclk),
    .NCS(ncs), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe),
    .PIX_VALID(pix_valid), .PIX_VALUE(pix_value), .PIX_LAST(pix_last),
    .ILLUM_NEEDED(illum), .BOUND_BUSY(busy), .LED_CTRL(led),
    .COUNT_DENSITY_SELECT(dens), .PORT_PULLUP_ON(pull_on),
    .GAIN_LOOP_OFF(gain_off), .FRAME_RATE_LOCK(rate_lock),
    .SELF_TEST_RUN(run), .TEST_RESULT(result), .FRAME_DONE(done));
  isc_host_model host_u (.SCLK(sclk), .NCS(ncs), .MOSI(mosi), .MISO(miso));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // a write lands 2-3 cycles after its last rise
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b1, a}, d, rd);
    tick(10);
  endtask : wr
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({1'b0, a}, 8'h00, rd);
    chk(rd, e);
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(7'h0a, 8'h09);
    rd_chk(7'h0b, 8'h00);
    rd_chk(7'h06, 8'h00);
    rd_chk(7'h07, 8'h00);
    rd_chk(7'h08, 8'h00);
    chk({led, dens, pull_on}, 3'b101);
    chk(miso_oe, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic frame(input int n, input int base, input int step);
    int sum;
    int peak;
    int v;
    sum = 0;
    peak = 0;
    for (int i = 0; i < n; i++) begin
      v = (base + i * step) % 64;
      sum += v;
      if (v > peak) peak = v;
      pix_valid = 1'b1;
      pix_value = v[5:0];
      pix_last = (i == n - 1);
      tick(1);
    end
    pix_valid = 1'b0;
    pix_last = 1'b0;
    chk(done, 1'b1);
    rd_chk(7'h06, sum[15:8]);
    rd_chk(7'h07, peak[7:0]);
    $display("frame test done");
  endtask : frame
  task automatic t_setup;
    wr(7'h0a, 8'h50);
    rd_chk(7'h0a, 8'h59);
    chk(dens, 1'b1);
    chk(led, 1'b0);
    illum = 1'b1;
    tick(2);
    chk(led, 1'b1);
    wr(7'h0a, 8'h09);
    illum = 1'b0;
    tick(2);
    chk({led, dens}, 2'b10);
    $display("setup test done");
  endtask : t_setup
  task automatic t_ext;
    wr(7'h0b, 8'h07);
    chk({pull_on, gain_off, rate_lock}, 3'b011);
    busy = 1'b1;
    tick(2);
    rd_chk(7'h0b, 8'h87);
    busy = 1'b0;
    // the sum register is read-only
    wr(7'h06, 8'hff);
    rd_chk(7'h06, 8'hdd);
    wr(7'h0b, 8'h00);
    chk({pull_on, gain_off, rate_lock}, 3'b100);
    $display("extended test done");
  endtask : t_ext
  task automatic t_check;
    int k;
    nrst = 1'b0; // fresh hardware reset first
    tick(10);
    nrst = 1'b1;
    tick(2);
    wr(7'h0b, 8'h07);
    // the check starts before the transfer's tail ends, so time it alongside
    fork
      host_u.xfer(8'h8a, 8'h79, rd);
      begin
        k = 0;
        while (run !== 1'b1 && k < 100) begin
          tick(1);
          k++;
        end
        chk(run, 1'b1);
        k = 0;
        while (run === 1'b1 && k < TC + 10) begin
          tick(1);
          k++;
        end
        chk(k >= TC - 1 && k <= TC + 1, 1'b1);
      end
    join
    tick(3);
    chk(result, 16'h1bbf);
    chk({dens, pull_on, gain_off, rate_lock}, 4'b0100);
    rd_chk(7'h0d, 8'h1b);
    rd_chk(7'h0c, 8'hbf);
    rd_chk(7'h0a, 8'h09);
    $display("self-check test done");
  endtask : t_check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(2);
    t_reset();
    frame(900, 63, 0);
    t_setup();
    t_ext();
    frame(37, 3, 5);
    t_check();
    complete_run();
  end
endmodule : image_stats_and_config_regs_test
`default_nettype wire
